// ---- src/tsp_pkg.sv ----
// constants, register map and carrier types for the timeslot/modem serial port
// Operation
// - short slot: at most eight bits, then release
// - entry assumes short; third bit picks frame
// - frame type decided per transfer, per direction
// - mode change may need one frame
// - long: first bit at strobe/clock rise
// - long: keep sending while strobe high
// - long: receive on falls while strobe high
// - slots may be four clocks apart
// - short: sync pulse, then eight rising bits
// - short: capture eight falls after sync
// - masked bit: skip receive, drive one/Z
// - mask sets shared transparent byte alignment
// - link clocks at most half bus clock
// - modem: transmit on fall, receive on rise
// - modem: request-to-send low while data waits
// - status bits follow clear-to-send, carrier-detect
// - clear-to-send lost: abort, resend later
// - no bit masking in modem mode
// - modem sync: boundary 1.5 clocks later
// - alignment kept; each sync pulse realigns
// - sync clears modulo-eight load counter
// - mask zero active, one ignored
// - serial data least significant bit first
package tsp_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_CTRL = 5'h00; // mode and enables
    localparam logic [4:0] ADDR_MASK = 5'h04; // bit mask / alignment
    localparam logic [4:0] ADDR_TXDATA = 5'h08; // transmit holding byte
    localparam logic [4:0] ADDR_RXDATA = 5'h0c; // last received byte
    localparam logic [4:0] ADDR_STATUS = 5'h10; // line and engine state
    localparam int ST_ABORT = 5; // write one here clears the abort flag
    localparam logic [7:0] MASK_RST = 8'h00; // all positions active
    localparam logic [7:0] FILL_BYTE = 8'hff; // idle fill when nothing waits
    localparam logic [3:0] BIT_CAP = 4'hf; // bit counter saturation
    localparam logic [3:0] THIRD_BIT = 4'h3; // tx count in third bit-time
    localparam logic [2:0] LAST_BIT = 3'h7; // eighth bit of a byte
    // line mode of the channel
    typedef enum logic [1:0] {MODE_OFF, MODE_SLOT, MODE_MODEM} mode_e;
    // control register layout
    typedef struct packed {
        logic transparent; // transparent byte alignment
        logic mask_drive;  // masked bit drives one instead of Z
        logic tx_en;       // transmit enable
        mode_e mode;
    } ctrl_s;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // status register layout
    typedef struct packed {
        logic rx_full;  // byte waiting in RXDATA
        logic abort;    // frame aborted on lost clear-to-send
        logic tx_pend;  // byte waiting to be sent
        logic rx_long;  // receiver in long-frame timing
        logic tx_long;  // transmitter in long-frame timing
        logic cd;       // carrier detect active
        logic cts;      // clear to send active
    } status_s;
    // external line inputs, all asynchronous to clock
    typedef struct packed {
        logic tx_clk;
        logic rx_clk;
        logic tx_stb;    // slot_assigner transmit strobe
        logic rx_stb;    // slot_assigner receive strobe
        logic rx_d;
        logic cts_n;
        logic cd_n;
        logic tx_sync_n; // transparent modem transmit sync
        logic rx_sync_n; // transparent modem receive sync
    } pins_s;
    localparam logic [8:0] PINS_IDLE = 9'h00f; // inactive levels
endpackage

// ---- src/tsp_serial_port.sv ----
// timeslot and modem serial port of one channel with its register file
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tsp_serial_port (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [tsp_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire tsp_pkg::pins_s pins,
    output logic tx_data,
    output logic tx_data_oe,
    output logic rts_n,
    output logic fifo_load,
    output logic [7:0] rx_byte
);
    import tsp_pkg::*;

    // first zero of the mask marks the transparent byte boundary
    function automatic logic [2:0] first_zero(input logic [7:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (!m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    pins_s s1_r, s2_r, s3_r; // synchroniser stages and edge history
    ctrl_s ctrl_r; // control register
    logic [7:0] mask_r; // bit mask register
    logic [7:0] hold_r; // transmit holding byte
    logic tx_pend_r, abort_r, rx_full_r; // sticky and pending flags
    mode_e mode_q_r; // mode of the previous cycle
    logic [31:0] rdata_r;
    logic tx_data_r, tx_oe_r, rts_n_r, fifo_load_r;
    logic [7:0] rx_byte_r;
    // transmit slot state
    logic tx_act_r, tx_long_r, tx_long_nxt_r, tx_stb_f_r;
    logic [3:0] tx_bit_r;
    // transmit byte state
    logic [7:0] tx_sh_r;
    logic [2:0] tx_cnt_r;
    logic tx_busy_r, tx_sdly_r;
    logic [1:0] cts_hi_r; // falls seen with clear-to-send inactive
    // receive slot and byte state
    logic rx_act_r, rx_long_r, rx_long_nxt_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic [2:0] rx_cnt_r;
    logic [1:0] rx_sdly_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // two flops before any logic; the third stage only feeds edge detection
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_r <= pins_s'(PINS_IDLE);
            s2_r <= pins_s'(PINS_IDLE);
            s3_r <= pins_s'(PINS_IDLE);
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // edges of the sampled link clocks and strobe; link clocks must stay
    // below half the bus clock or edges are missed
    logic tx_rise, tx_fall, rx_rise, rx_fall, tx_stb_rise;
    assign tx_rise = s2_r.tx_clk & ~s3_r.tx_clk;
    assign tx_fall = ~s2_r.tx_clk & s3_r.tx_clk;
    assign rx_rise = s2_r.rx_clk & ~s3_r.rx_clk;
    assign rx_fall = ~s2_r.rx_clk & s3_r.rx_clk;
    assign tx_stb_rise = s2_r.tx_stb & ~s3_r.tx_stb;

    logic mode_ts, mode_md, ts_entry;
    logic [2:0] align;
    assign mode_ts = ctrl_r.mode == MODE_SLOT;
    assign mode_md = ctrl_r.mode == MODE_MODEM;
    assign ts_entry = mode_ts && mode_q_r != MODE_SLOT;
    assign align = first_zero(mask_r);

    // transmit decode: start, continue, end of a slot
    logic tx_start, tx_more, tx_end, tx_emit, tx_masked, tx_force;
    logic tx_bnd, tx_take, tx_step, tx_abort;
    logic [2:0] tx_p;
    logic [7:0] tx_cur;
    assign tx_p = tx_bit_r[2:0];
    // long starts on the strobe edge, short on the clock after the sync
    assign tx_start = !tx_act_r && (tx_long_r ? tx_stb_rise : (tx_rise && tx_stb_f_r));
    assign tx_more = tx_act_r && tx_rise && (tx_bit_r < 4'h8 || (tx_long_r && s2_r.tx_stb));
    assign tx_end = tx_act_r && tx_rise && !tx_more;
    assign tx_emit = (mode_ts && (tx_start || tx_more)) || (mode_md && tx_fall);
    // masking only in plain timeslot operation
    assign tx_masked = mode_ts && !ctrl_r.transparent && mask_r[tx_p];
    assign tx_force = ctrl_r.transparent && (mode_ts ? tx_p == align : tx_sdly_r);
    assign tx_bnd = tx_cnt_r == 3'h0 || tx_force;
    // modem takes a new frame only while clear-to-send is active
    assign tx_take = tx_bnd && tx_pend_r && (mode_ts || !s2_r.cts_n);
    assign tx_cur = tx_bnd ? (tx_take ? hold_r : FILL_BYTE) : tx_sh_r;
    assign tx_abort = mode_md && tx_busy_r && tx_fall && s2_r.cts_n && cts_hi_r != 2'h0;
    assign tx_step = tx_emit && !tx_masked && !tx_abort;

    // transmit slot tracking and frame-type decision
    always_ff @(posedge clock) begin
        if (!resetn || ts_entry) begin
            tx_act_r <= 1'b0;
            tx_bit_r <= 4'h0;
            tx_long_r <= 1'b0;
            tx_long_nxt_r <= 1'b0;
            tx_stb_f_r <= 1'b0;
        end else if (mode_ts) begin
            if (tx_fall) begin
                tx_stb_f_r <= s2_r.tx_stb;
                // strobe level in the third bit-time picks the next frame type
                if (tx_act_r && tx_bit_r == THIRD_BIT) begin
                    tx_long_nxt_r <= s2_r.tx_stb;
                end
            end
            if (tx_start) begin
                tx_act_r <= 1'b1;
                tx_bit_r <= 4'h1;
            end else if (tx_more) begin
                tx_bit_r <= (tx_bit_r == BIT_CAP) ? BIT_CAP : tx_bit_r + 4'h1;
            end else if (tx_end) begin
                // timing switches only here, so a change costs one frame
                tx_act_r <= 1'b0;
                tx_bit_r <= 4'h0;
                tx_long_r <= tx_long_nxt_r;
            end
        end
    end

    // transmit shift register, lsb first
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tx_sh_r <= FILL_BYTE;
            tx_cnt_r <= 3'h0;
            tx_busy_r <= 1'b0;
        end else if (tx_abort) begin
            tx_sh_r <= FILL_BYTE;
            tx_cnt_r <= 3'h0;
            tx_busy_r <= 1'b0;
        end else if (tx_step) begin
            tx_sh_r <= {1'b1, tx_cur[7:1]};
            tx_cnt_r <= tx_bnd ? 3'h1 : tx_cnt_r + 3'h1;
            if (tx_bnd) begin
                tx_busy_r <= tx_take;
            end
        end
    end

    // modem transmit sync and clear-to-send watch, both on falling edges
    always_ff @(posedge clock) begin
        if (!resetn) begin
            tx_sdly_r <= 1'b0;
            cts_hi_r <= 2'h0;
        end else if (tx_fall) begin
            tx_sdly_r <= mode_md && !s2_r.tx_sync_n;
            if (!s2_r.cts_n) begin
                cts_hi_r <= 2'h0;
            end else if (cts_hi_r != 2'h3) begin
                cts_hi_r <= cts_hi_r + 2'h1;
            end
        end
    end

    // transmit pin; outside the slot the pin floats
    always_ff @(posedge clock) begin
        if (!resetn || !(mode_ts || mode_md)) begin
            tx_data_r <= 1'b1;
            tx_oe_r <= 1'b0;
        end else if (tx_abort) begin
            tx_data_r <= 1'b1;
            tx_oe_r <= ctrl_r.tx_en;
        end else if (tx_emit) begin
            tx_data_r <= tx_masked ? 1'b1 : tx_cur[0];
            tx_oe_r <= tx_masked ? ctrl_r.mask_drive : ctrl_r.tx_en;
        end else if (mode_ts && tx_end) begin
            tx_oe_r <= 1'b0;
        end
    end

    // receive decode
    logic rx_samp, rx_end, rx_masked, rx_force, rx_bnd, rx_step;
    logic [2:0] rx_p;
    logic [7:0] rx_new;
    assign rx_p = rx_bit_r[2:0];
    // long samples every fall with strobe high; short only inside the slot
    assign rx_samp = mode_ts && rx_fall && (rx_long_r ? s2_r.rx_stb : rx_act_r);
    assign rx_end = rx_fall && rx_act_r && (rx_long_r ? !s2_r.rx_stb : rx_bit_r == 4'h7);
    assign rx_masked = !ctrl_r.transparent && mask_r[rx_p];
    assign rx_force = ctrl_r.transparent && (mode_ts ? rx_p == align : rx_sdly_r[1]);
    // modem samples on rising edges while carrier detect is active
    assign rx_step = (rx_samp && !rx_masked) || (mode_md && rx_rise && !s2_r.cd_n);
    assign rx_bnd = rx_cnt_r == 3'h0 || rx_force;
    assign rx_new = {s2_r.rx_d, rx_sh_r[7:1]};

    // receive slot tracking, independent of the transmitter
    always_ff @(posedge clock) begin
        if (!resetn || ts_entry) begin
            rx_act_r <= 1'b0;
            rx_bit_r <= 4'h0;
            rx_long_r <= 1'b0;
            rx_long_nxt_r <= 1'b0;
        end else if (mode_ts && rx_fall) begin
            if (rx_samp && rx_bit_r == 4'h2) begin
                rx_long_nxt_r <= s2_r.rx_stb;
            end
            if (!rx_act_r && s2_r.rx_stb) begin
                // short: the sync fall itself carries no data
                rx_act_r <= 1'b1;
                rx_bit_r <= rx_long_r ? 4'h1 : 4'h0;
            end else if (rx_end) begin
                rx_act_r <= 1'b0;
                rx_bit_r <= 4'h0;
                rx_long_r <= rx_long_nxt_r;
            end else if (rx_samp) begin
                rx_bit_r <= (rx_bit_r == BIT_CAP) ? BIT_CAP : rx_bit_r + 4'h1;
            end
        end
    end

    // receive shift register and modulo-eight load counter
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_byte_r <= 8'h00;
            fifo_load_r <= 1'b0;
        end else begin
            fifo_load_r <= 1'b0;
            if (rx_step) begin
                rx_sh_r <= rx_new;
                // a sync restarts the count, so frequent syncs never load
                if (rx_bnd) begin
                    rx_cnt_r <= 3'h1;
                end else if (rx_cnt_r == LAST_BIT) begin
                    rx_cnt_r <= 3'h0;
                    rx_byte_r <= rx_new;
                    fifo_load_r <= 1'b1;
                end else begin
                    rx_cnt_r <= rx_cnt_r + 3'h1;
                end
            end
        end
    end

    // modem receive sync: seen on a fall, boundary on the rise after the next fall
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rx_sdly_r <= 2'h0;
        end else if (rx_fall) begin
            rx_sdly_r <= {rx_sdly_r[0], mode_md && !s2_r.rx_sync_n};
        end
    end

    // software registers and flags; hardware set wins over clear
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctrl_r <= ctrl_s'(CTRL_RST);
            mask_r <= MASK_RST;
            hold_r <= 8'h00;
            tx_pend_r <= 1'b0;
            abort_r <= 1'b0;
            rx_full_r <= 1'b0;
            mode_q_r <= MODE_OFF;
        end else begin
            mode_q_r <= ctrl_r.mode;
            if (wr_stb && addr == ADDR_CTRL) begin
                ctrl_r <= ctrl_s'(wdata[4:0]);
            end
            if (wr_stb && addr == ADDR_MASK) begin
                mask_r <= wdata[7:0];
            end
            // a write or an abort leaves a byte waiting; resend uses hold_r
            if (wr_stb && addr == ADDR_TXDATA) begin
                hold_r <= wdata[7:0];
                tx_pend_r <= 1'b1;
            end else if (tx_abort) begin
                tx_pend_r <= 1'b1;
            end else if (tx_step && tx_take) begin
                tx_pend_r <= 1'b0;
            end
            if (tx_abort) begin
                abort_r <= 1'b1;
            end else if (wr_stb && addr == ADDR_STATUS && wdata[ST_ABORT]) begin
                abort_r <= 1'b0;
            end
            if (fifo_load_r) begin
                rx_full_r <= 1'b1;
            end else if (rd_stb && addr == ADDR_RXDATA) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // read data for one cycle after the strobe, zero elsewhere
    status_s status;
    assign status = '{rx_full: rx_full_r, abort: abort_r, tx_pend: tx_pend_r,
                      rx_long: rx_long_r, tx_long: tx_long_r,
                      cd: !s2_r.cd_n, cts: !s2_r.cts_n};
    always_ff @(posedge clock) begin
        if (!resetn || !rd_stb) begin
            rdata_r <= 32'h0;
        end else begin
            case (addr)
                ADDR_CTRL: rdata_r <= {27'h0, ctrl_r};
                ADDR_MASK: rdata_r <= {24'h0, mask_r};
                ADDR_TXDATA: rdata_r <= {24'h0, hold_r};
                ADDR_RXDATA: rdata_r <= {24'h0, rx_byte_r};
                ADDR_STATUS: rdata_r <= {25'h0, status};
                default: rdata_r <= 32'h0;
            endcase
        end
    end

    // request-to-send while data waits or a frame runs
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rts_n_r <= 1'b1;
        end else begin
            rts_n_r <= !(mode_md && (tx_pend_r || tx_busy_r));
        end
    end

    assign rdata = rdata_r;
    assign tx_data = tx_data_r;
    assign tx_data_oe = tx_oe_r;
    assign rts_n = rts_n_r;
    assign fifo_load = fifo_load_r;
    assign rx_byte = rx_byte_r;

    a_slot_release:
    assert property ($fell(tx_act_r) && mode_ts |-> !tx_oe_r)
    else $error("pin still driven after slot end");
    a_entry_short:
    assert property ($rose(mode_ts) |=> !tx_long_r && !rx_long_r && !tx_act_r)
    else $error("timeslot entry not in short-frame");
    a_long_latch:
    assert property (tx_end && mode_ts && !ts_entry |=> tx_long_r == $past(tx_long_nxt_r))
    else $error("frame type not taken at slot end");
    a_short_eight:
    assert property (tx_act_r && !tx_long_r |-> tx_bit_r <= 4'h8)
    else $error("short slot longer than eight bits");
    a_load_wrap:
    assert property (fifo_load_r |-> $past(rx_step) && $past(rx_cnt_r) == 3'h7 && !$past(rx_force))
    else $error("load without eight counted bits");
    // a frame that ends with nothing waiting may release request-to-send at once
    a_rts_follow:
    assert property (mode_md && (tx_pend_r || tx_busy_r) |=> !rts_n_r)
    else $error("request-to-send not asserted");
    a_abort_resend:
    assert property (tx_abort |=> tx_pend_r && tx_cnt_r == 3'h0 && abort_r && !tx_busy_r)
    else $error("abort did not rearm the frame");
    a_mask_skip:
    assert property (rx_samp && rx_masked |=> rx_cnt_r == $past(rx_cnt_r))
    else $error("masked bit was received");
    c_byte_load: cover property (fifo_load_r);
    c_abort: cover property (tx_abort);
    c_long_frame: cover property ($rose(tx_long_r));
    // modem byte delivery and a masked transmit bit-time
    c_modem_load: cover property (mode_md && fifo_load_r);
    c_masked_bit: cover property (tx_emit && tx_masked);
endmodule // tsp_serial_port
`default_nettype wire

// ---- verification/highway_model.sv ----
// far-side model: pcm highway with slot assigner, or a synchronous modem
`timescale 1ns/1ps
`default_nettype none
module highway_model (
    input wire logic clock,
    input wire logic tx_data,
    input wire logic tx_data_oe,
    output var tsp_pkg::pins_s pins
);
    import tsp_pkg::*;
    logic modem_r; // modem timing: receive data moves on falls
    logic [1:0] mid_q[$]; // {oe, data} seen just before each fall
    logic [1:0] st_q[$]; // {oe, data} seen just before each rise
    // lines idle, clocks low
    initial begin
        pins = PINS_IDLE;
        modem_r = 1'b0;
    end
    // flow-control lines and which edge carries receive data
    task automatic set_lines(input logic modem, input logic cts_n, input logic cd_n);
        @(posedge clock);
        modem_r <= modem;
        pins.cts_n <= cts_n;
        pins.cd_n <= cd_n;
    endtask
    // one link period of 32 bus clocks, far below half the bus clock rate
    task automatic tick(input logic stb, input logic sync_n, input logic d);
        @(posedge clock);
        st_q.push_back({tx_data_oe, tx_data});
        pins.tx_clk <= 1'b1;
        pins.rx_clk <= 1'b1;
        pins.tx_stb <= stb;
        pins.rx_stb <= stb;
        pins.tx_sync_n <= sync_n;
        pins.rx_sync_n <= sync_n;
        if (!modem_r) begin
            pins.rx_d <= d;
        end
        repeat (16) @(posedge clock);
        mid_q.push_back({tx_data_oe, tx_data});
        pins.tx_clk <= 1'b0;
        pins.rx_clk <= 1'b0;
        if (modem_r) begin
            pins.rx_d <= d;
        end
        repeat (15) @(posedge clock);
    endtask
    // n periods: strobe high in the first hi, sync low in the first if asked,
    // receive byte from period off; outside it the data line keeps toggling
    // so a stale level is never mistaken for data; clocks stop afterwards
    task automatic run(input int hi, input int off, input logic [7:0] d, input int n,
        input logic sync0);
        int k;
        mid_q.delete();
        st_q.delete();
        for (int i = 0; i < n; i++) begin
            k = i - off;
            tick(i < hi, !(sync0 && i == 0), (k >= 0 && k < 8) ? d[k] : ~pins.rx_d);
        end
    endtask
endmodule // highway_model
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the timeslot and modem serial port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsp_pkg::*;
    logic clock, resetn, wr_stb, rd_stb, tx_data, tx_data_oe, rts_n, fifo_load;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata, v;
    logic [7:0] rx_byte;
    pins_s pins;
    int bad_count = 0;
    int checks_done = 0;
    int loads = 0; // fifo_load pulses seen
    tsp_serial_port i_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pins(pins), .tx_data(tx_data),
        .tx_data_oe(tx_data_oe), .rts_n(rts_n), .fifo_load(fifo_load), .rx_byte(rx_byte));
    highway_model i_far (.clock(clock), .tx_data(tx_data), .tx_data_oe(tx_data_oe),
        .pins(pins));
    // 200 MHz bus clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // count load pulses; a pulse is one cycle wide
    always @(posedge clock) begin
        if (fifo_load === 1'b1) begin
            loads <= loads + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    // eight captured bits, lsb first; rise picks the samples taken before rises
    task automatic tx_bits(input int first, input logic [7:0] b, input logic rise);
        for (int i = 0; i < 8; i++) begin
            check(rise ? i_far.st_q[first + i] : i_far.mid_q[first + i], {1'b1, b[i]});
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // reset values, unmapped space reads zero
    task automatic t_reset;
        rd(ADDR_CTRL, v);
        check(v, 32'h0);
        rd(ADDR_MASK, v);
        check(v, 32'h0);
        rd(ADDR_STATUS, v);
        check(v, 32'h0);
        rd(5'h14, v);
        check(v, 32'h0);
        check({tx_data_oe, rts_n}, 2'b01);
    endtask
    // short frames: transmitter held off first, then two slots four clocks apart
    task automatic t_short;
        int n0;
        wr(ADDR_CTRL, 32'h01);
        i_far.run(1, 1, 8'h00, 12, 1'b0);
        for (int i = 0; i < 12; i++) begin
            check(i_far.mid_q[i][1], 1'b0);
        end
        wr(ADDR_CTRL, 32'h05);
        wr(ADDR_TXDATA, 32'ha5);
        n0 = loads;
        i_far.run(1, 1, 8'h3c, 12, 1'b0);
        tx_bits(1, 8'ha5, 1'b0);
        check(i_far.mid_q[9][1], 1'b0);
        check(rx_byte, 8'h3c);
        i_far.run(1, 1, 8'hc3, 10, 1'b0);
        tx_bits(1, FILL_BYTE, 1'b0);
        check(rx_byte, 8'hc3);
        check(loads - n0, 2);
        rd(ADDR_STATUS, v);
        check(v[3:2], 2'b00);
        check(v[6], 1'b1);
        rd(ADDR_RXDATA, v);
        check(v, 32'hc3);
        rd(ADDR_STATUS, v);
        check(v[6], 1'b0);
    endtask
    // subrate mask: only bits 2 and 3 active, drive setting alternated
    task automatic t_mask;
        logic [1:0] ign; // released bit: its data level is free
        wr(ADDR_MASK, 32'hf3);
        wr(ADDR_TXDATA, 32'h00);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CTRL, m[0] ? 32'h0d : 32'h05);
            i_far.run(1, 1, 8'h00, 12, 1'b0);
            for (int i = 0; i < 8; i++) begin
                ign = ((i < 2 || i > 3) && !m[0]) ? 2'b01 : 2'b00;
                check(i_far.mid_q[i + 1] | ign, (i < 2 || i > 3) ? {m[0], 1'b1} : 2'b10);
            end
        end
        wr(ADDR_MASK, 32'h00);
    endtask
    // long frames: a wide strobe picks long timing, then a slot past eight bits
    task automatic t_long;
        wr(ADDR_TXDATA, 32'h96);
        i_far.run(8, 1, 8'h00, 12, 1'b0);
        rd(ADDR_STATUS, v);
        check(v[3:2], 2'b11);
        wr(ADDR_TXDATA, 32'h69);
        i_far.run(10, 0, 8'h5e, 14, 1'b0);
        tx_bits(0, 8'h69, 1'b0);
        check(i_far.mid_q[9][1], 1'b1);
        check(i_far.mid_q[10][1], 1'b0);
        check(rx_byte, 8'h5e);
    endtask
    // modem: flow lines, sync alignment with mask ignored, too-frequent sync
    task automatic t_modem;
        int n0;
        i_far.set_lines(1'b1, 1'b0, 1'b0);
        wr(ADDR_MASK, 32'hff);
        wr(ADDR_CTRL, 32'h16);
        rd(ADDR_STATUS, v);
        check(v[1:0], 2'b11);
        wr(ADDR_TXDATA, 32'h5a);
        repeat (2) @(posedge clock);
        #1 check(rts_n, 1'b0);
        i_far.run(0, 1, 8'hc5, 11, 1'b1);
        tx_bits(2, 8'h5a, 1'b1);
        check(rx_byte, 8'hc5);
        n0 = loads;
        for (int i = 0; i < 3; i++) begin
            i_far.run(0, 1, 8'h00, 4, 1'b1);
        end
        check(loads - n0, 0);
        i_far.set_lines(1'b1, 1'b1, 1'b1);
        // line levels need the two synchroniser flops before status shows them
        repeat (3) @(posedge clock);
        rd(ADDR_STATUS, v);
        check(v[1:0], 2'b00);
        // frame started with clear-to-send active, then three falls without it
        wr(ADDR_TXDATA, 32'h33);
        i_far.set_lines(1'b1, 1'b0, 1'b1);
        i_far.run(0, 1, 8'h00, 3, 1'b1);
        i_far.set_lines(1'b1, 1'b1, 1'b1);
        i_far.run(0, 1, 8'h00, 3, 1'b0);
        rd(ADDR_STATUS, v);
        check(v[5:4], 2'b11);
        check(rts_n, 1'b0);
        wr(ADDR_STATUS, 32'h20);
        rd(ADDR_STATUS, v);
        check(v[5:4], 2'b01);
    endtask
    // reset, then the scenarios in order
    initial begin
        resetn = 1'b0;
        addr = '0;
        wdata = 32'h0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset;
        t_short;
        t_mask;
        t_long;
        t_modem;
        finish_test;
    end
    // watchdog: the run needs about 4500 cycles
    initial begin
        repeat (30000) @(posedge clock);
        bad_count++;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
